// ### otfs_defs.vh
// Constants for the output terminal function select block
// How it works
// R1: Five open-collector terminals, one relay, own selects
// R2: Per-output polarity: normally open or inverted
// R3: Fault mode 01/02 puts 3/4-bit code out
// R4: Code terminals ignore their function selects
// R5: Codes 00,01,02,06 map run and arrival
// R6: Codes 03 and 26 give overload notices
// R7: Codes 04 and 31 give PID flags
// R8: Codes 08 and 09 give power loss, undervoltage
// R9: Codes 11 and 12 give time-exceeded flags
// R10: Code 13 gives thermal protection alarm
// R11: Codes 39,40,42 give maintenance warnings
// R12: Codes 21 and 22 give zero-Hz, deviation
// R13: Codes 24 and 25 give second arrival set
// R14: Codes 27,28,29 give analog input disconnects
// R15: Code 32 gives comm line disconnect
// R16: Codes 33 to 38 give logic results
// R17: Codes 44 to 49 give sequence outputs
// R18: Code 43 low current, 41 start contact
// R19: Undefined codes give deasserted before polarity
`ifndef OTFS_DEFS_VH
`define OTFS_DEFS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define OTFS_ADDR_TERM_FUNC0 8'h00
`define OTFS_ADDR_RELAY_FUNC 8'h14
`define OTFS_ADDR_POLARITY 8'h18
`define OTFS_ADDR_FAULT_MODE 8'h1c
`define OTFS_ADDR_STATUS 8'h20

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OTFS_RST_TERM_FUNC 6'h00
`define OTFS_RST_RELAY_FUNC 6'h05
`define OTFS_RST_POLARITY 6'h20
`define OTFS_RST_FAULT_MODE 2'h0

// ----------------------------------------------------------------
// Fault code output modes
// ----------------------------------------------------------------
`define OTFS_FAULT_OFF 2'h0
`define OTFS_FAULT_3BIT 2'h1
`define OTFS_FAULT_4BIT 2'h2

// ----------------------------------------------------------------
// Function selection codes
// ----------------------------------------------------------------
`define OTFS_CODE_RUN 6'h00
`define OTFS_CODE_CONST_SPEED 6'h01
`define OTFS_CODE_FREQ_OVER 6'h02
`define OTFS_CODE_OVERLOAD1 6'h03
`define OTFS_CODE_PID_DEV 6'h04
`define OTFS_CODE_FAULT 6'h05
`define OTFS_CODE_FREQ_REACHED 6'h06
`define OTFS_CODE_OVER_TORQUE 6'h07
`define OTFS_CODE_POWER_LOSS 6'h08
`define OTFS_CODE_SUPPLY_LOW 6'h09
`define OTFS_CODE_TORQUE_LIMIT 6'h0a
`define OTFS_CODE_RUN_TIME 6'h0b
`define OTFS_CODE_ON_TIME 6'h0c
`define OTFS_CODE_THERMAL 6'h0d
`define OTFS_CODE_BRAKE_RELEASE 6'h13
`define OTFS_CODE_BRAKE_ERROR 6'h14
`define OTFS_CODE_ZERO_HZ 6'h15
`define OTFS_CODE_SPEED_DEV 6'h16
`define OTFS_CODE_POS_DONE 6'h17
`define OTFS_CODE_FREQ_OVER2 6'h18
`define OTFS_CODE_FREQ_REACHED2 6'h19
`define OTFS_CODE_OVERLOAD2 6'h1a
`define OTFS_CODE_VIN_DISC 6'h1b
`define OTFS_CODE_IIN_DISC 6'h1c
`define OTFS_CODE_VIN2_DISC 6'h1d
`define OTFS_CODE_PID_FB 6'h1f
`define OTFS_CODE_COMM_DISC 6'h20
`define OTFS_CODE_LOGIC_BASE 6'h21
`define OTFS_CODE_CAP_LIFE 6'h27
`define OTFS_CODE_FAN_DROP 6'h28
`define OTFS_CODE_START_CONTACT 6'h29
`define OTFS_CODE_HEATSINK 6'h2a
`define OTFS_CODE_LOW_CURRENT 6'h2b
`define OTFS_CODE_SEQ_BASE 6'h2c
`define OTFS_CODE_READY 6'h32
`define OTFS_CODE_FWD_ROT 6'h33
`define OTFS_CODE_REV_ROT 6'h34
`define OTFS_CODE_MAJOR_FAIL 6'h35
`define OTFS_CODE_WINCMP_BASE 6'h36

`endif

// ### otfs_core.v
// Output terminal function select with APB register access
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "otfs_defs.vh"

module otfs_core (
   input wire i_core_clk,
   input wire i_rstn,
   // APB slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   // Internal status sources, same clock domain
   input wire i_running,
   input wire i_constant_speed_reached,
   input wire i_set_freq_overreached,
   input wire i_set_freq_reached,
   input wire i_set_freq_overreached_second,
   input wire i_set_freq_reached_second,
   input wire i_overload_notice_first,
   input wire i_overload_notice_second,
   input wire i_pid_deviation_flag,
   input wire i_pid_feedback_compare,
   input wire i_fault_flag,
   input wire i_over_torque,
   input wire i_momentary_power_loss,
   input wire i_supply_low_flag,
   input wire i_torque_limited,
   input wire i_run_time_exceeded,
   input wire i_power_on_time_exceeded,
   input wire i_thermal_protect_alarm,
   input wire i_brake_release,
   input wire i_brake_error,
   input wire i_zero_hertz_detect,
   input wire i_speed_deviation_max,
   input wire i_position_done,
   input wire i_voltage_input_disconnect,
   input wire i_current_input_disconnect,
   input wire i_second_voltage_input_disconnect,
   input wire i_comm_line_disconnect,
   input wire [5:0] i_logic_result,
   input wire i_capacitor_life_warning,
   input wire i_fan_speed_drop,
   input wire i_start_contact_flag,
   input wire i_heatsink_overheat_warning,
   input wire i_low_current_flag,
   input wire [5:0] i_sequence_output,
   input wire i_drive_ready,
   input wire i_forward_rotation,
   input wire i_reverse_rotation,
   input wire i_major_failure,
   input wire [2:0] i_window_compare,
   input wire [3:0] i_fault_code_bits,
   // Open-collector terminals and relay
   input wire [4:0] i_terminal_pin,
   output reg [4:0] o_terminal_out,
   output reg [4:0] o_terminal_oe_n,
   output reg o_relay_coil
);

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   // Entries 0..4 are the terminals, entry 5 the relay
   reg [5:0] func_reg [0:5];
   reg [5:0] polarity_reg;
   reg [1:0] fault_mode_reg;
   reg [4:0] pin_meta_reg;
   reg [4:0] pin_sync_reg;
   reg [5:0] active_reg;
   reg [5:0] active_next;
   reg [63:0] source_vec;
   reg [31:0] rdata_next;
   reg addr_ok;
   integer k;
   integer r;

   wire apb_setup;
   wire apb_write;
   wire [5:0] word_idx;
   wire [3:0] code_mask;

   assign apb_setup = i_psel & ~i_penable;
   assign apb_write = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
   assign word_idx = i_paddr[7:2];

   // ----------------------------------------------------------------
   // Status source map, indexed by selection code
   // ----------------------------------------------------------------
   // Unlisted codes stay zero, so an undefined select reads as deasserted
   always @* begin
      source_vec = 64'h0; // R19
      source_vec[`OTFS_CODE_RUN] = i_running; // R5
      source_vec[`OTFS_CODE_CONST_SPEED] = i_constant_speed_reached; // R5
      source_vec[`OTFS_CODE_FREQ_OVER] = i_set_freq_overreached; // R5
      source_vec[`OTFS_CODE_FREQ_REACHED] = i_set_freq_reached; // R5
      source_vec[`OTFS_CODE_OVERLOAD1] = i_overload_notice_first; // R6
      source_vec[`OTFS_CODE_OVERLOAD2] = i_overload_notice_second; // R6
      source_vec[`OTFS_CODE_PID_DEV] = i_pid_deviation_flag; // R7
      source_vec[`OTFS_CODE_PID_FB] = i_pid_feedback_compare; // R7
      source_vec[`OTFS_CODE_FAULT] = i_fault_flag;
      source_vec[`OTFS_CODE_OVER_TORQUE] = i_over_torque;
      source_vec[`OTFS_CODE_POWER_LOSS] = i_momentary_power_loss; // R8
      source_vec[`OTFS_CODE_SUPPLY_LOW] = i_supply_low_flag; // R8
      source_vec[`OTFS_CODE_TORQUE_LIMIT] = i_torque_limited;
      source_vec[`OTFS_CODE_RUN_TIME] = i_run_time_exceeded; // R9
      source_vec[`OTFS_CODE_ON_TIME] = i_power_on_time_exceeded; // R9
      source_vec[`OTFS_CODE_THERMAL] = i_thermal_protect_alarm; // R10
      source_vec[`OTFS_CODE_BRAKE_RELEASE] = i_brake_release;
      source_vec[`OTFS_CODE_BRAKE_ERROR] = i_brake_error;
      source_vec[`OTFS_CODE_ZERO_HZ] = i_zero_hertz_detect; // R12
      source_vec[`OTFS_CODE_SPEED_DEV] = i_speed_deviation_max; // R12
      source_vec[`OTFS_CODE_POS_DONE] = i_position_done;
      source_vec[`OTFS_CODE_FREQ_OVER2] = i_set_freq_overreached_second; // R13
      source_vec[`OTFS_CODE_FREQ_REACHED2] = i_set_freq_reached_second; // R13
      source_vec[`OTFS_CODE_VIN_DISC] = i_voltage_input_disconnect; // R14
      source_vec[`OTFS_CODE_IIN_DISC] = i_current_input_disconnect; // R14
      source_vec[`OTFS_CODE_VIN2_DISC] = i_second_voltage_input_disconnect; // R14
      source_vec[`OTFS_CODE_COMM_DISC] = i_comm_line_disconnect; // R15
      source_vec[`OTFS_CODE_CAP_LIFE] = i_capacitor_life_warning; // R11
      source_vec[`OTFS_CODE_FAN_DROP] = i_fan_speed_drop; // R11
      source_vec[`OTFS_CODE_HEATSINK] = i_heatsink_overheat_warning; // R11
      source_vec[`OTFS_CODE_START_CONTACT] = i_start_contact_flag; // R18
      source_vec[`OTFS_CODE_LOW_CURRENT] = i_low_current_flag; // R18
      source_vec[`OTFS_CODE_READY] = i_drive_ready;
      source_vec[`OTFS_CODE_FWD_ROT] = i_forward_rotation;
      source_vec[`OTFS_CODE_REV_ROT] = i_reverse_rotation;
      source_vec[`OTFS_CODE_MAJOR_FAIL] = i_major_failure;
      for (k = 0; k < 6; k = k + 1) begin
         source_vec[`OTFS_CODE_LOGIC_BASE + k] = i_logic_result[k]; // R16
         source_vec[`OTFS_CODE_SEQ_BASE + k] = i_sequence_output[k]; // R17
      end
      for (k = 0; k < 3; k = k + 1) begin
         source_vec[`OTFS_CODE_WINCMP_BASE + k] = i_window_compare[k];
      end
   end

   // ----------------------------------------------------------------
   // Per-output selection, fault code override and polarity
   // ----------------------------------------------------------------
   // Terminals carrying fault code bits; mode 03 is treated as off
   assign code_mask = (fault_mode_reg == `OTFS_FAULT_3BIT) ? 4'h7 : // R3
                      (fault_mode_reg == `OTFS_FAULT_4BIT) ? 4'hf : 4'h0; // R3

   wire [5:0] asserted_vec;
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_out
         wire selected;
         assign selected = source_vec[func_reg[g]]; // R1
         if (g < 4) begin : g_code
            // Function select is bypassed entirely while the code owns the pin
            assign asserted_vec[g] = code_mask[g] ? i_fault_code_bits[g] : selected; // R3 R4
         end else begin : g_plain
            assign asserted_vec[g] = selected;
         end
      end
   endgenerate

   // One process for the whole vector, so no bit has a second driver
   always @* begin
      active_next = asserted_vec ^ polarity_reg; // R2
   end

   // ----------------------------------------------------------------
   // Output flops and pin readback synchroniser
   // ----------------------------------------------------------------
   always @(posedge i_core_clk) begin
      if (!i_rstn) begin
         active_reg <= 6'h00;
         o_terminal_out <= 5'h00;
         o_terminal_oe_n <= 5'h1f;
         o_relay_coil <= 1'b0;
         pin_meta_reg <= 5'h00;
         pin_sync_reg <= 5'h00;
      end else begin
         active_reg <= active_next;
         // Open collector only ever pulls low; enable low means conducting
         o_terminal_out <= 5'h00;
         o_terminal_oe_n <= ~active_next[4:0]; // R1
         o_relay_coil <= active_next[5]; // R1
         pin_meta_reg <= i_terminal_pin;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // APB slave: one wait-free access phase, answer registered in setup
   // ----------------------------------------------------------------
   always @* begin
      rdata_next = 32'h0;
      addr_ok = 1'b1;
      if (word_idx < 6'h06) begin
         rdata_next[5:0] = func_reg[word_idx[2:0]];
      end else if (i_paddr == `OTFS_ADDR_POLARITY) begin
         rdata_next[5:0] = polarity_reg;
      end else if (i_paddr == `OTFS_ADDR_FAULT_MODE) begin
         rdata_next[1:0] = fault_mode_reg;
      end else if (i_paddr == `OTFS_ADDR_STATUS) begin
         rdata_next[5:0] = active_reg;
         rdata_next[12:8] = pin_sync_reg;
      end else begin
         addr_ok = 1'b0;
      end
      if (i_paddr[1:0] != 2'h0) begin
         addr_ok = 1'b0;
         rdata_next = 32'h0;
      end
   end

   always @(posedge i_core_clk) begin
      if (!i_rstn) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0;
      end else if (apb_setup) begin
         o_pready <= 1'b1;
         o_pslverr <= ~addr_ok | (i_pwrite & (i_paddr == `OTFS_ADDR_STATUS));
         o_prdata <= i_pwrite ? 32'h0 : rdata_next;
      end else begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0;
      end
   end

   always @(posedge i_core_clk) begin
      if (!i_rstn) begin
         for (r = 0; r < 5; r = r + 1) begin
            func_reg[r] <= `OTFS_RST_TERM_FUNC;
         end
         func_reg[5] <= `OTFS_RST_RELAY_FUNC;
         polarity_reg <= `OTFS_RST_POLARITY;
         fault_mode_reg <= `OTFS_RST_FAULT_MODE;
      end else if (apb_write) begin
         if (word_idx < 6'h06) begin
            func_reg[word_idx[2:0]] <= i_pwdata[5:0]; // R1
         end else if (i_paddr == `OTFS_ADDR_POLARITY) begin
            polarity_reg <= i_pwdata[5:0]; // R2
         end else if (i_paddr == `OTFS_ADDR_FAULT_MODE) begin
            fault_mode_reg <= i_pwdata[1:0]; // R3
         end
      end
   end

endmodule
`default_nettype wire

// ### otfs_core_asserts.sv
// Port-level assertions for the output terminal select block
`timescale 1ns/1ps
`default_nettype none
`include "otfs_defs.vh"
module otfs_chk (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_running,
   input wire logic i_fault_flag,
   input wire logic [3:0] i_fault_code_bits,
   input wire logic [4:0] o_terminal_out,
   input wire logic [4:0] o_terminal_oe_n,
   input wire logic o_relay_coil
);
   logic [1:0] mode_reg;
   logic [5:0] pol_reg;
   logic [5:0] sel4_reg;
   logic [5:0] rsel_reg;
   // Shadows track only committed writes, refused ones never land
   wire wr_ok = i_psel && i_penable && i_pwrite && o_pready && !o_pslverr;
   wire [3:0] code4 = ~(i_fault_code_bits ^ pol_reg[3:0]);
   wire [2:0] code3 = code4[2:0];
   wire run_oe_n = ~(i_running ^ pol_reg[4]);
   wire relay_on = i_fault_flag ^ pol_reg[5];
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         mode_reg <= `OTFS_RST_FAULT_MODE;
         pol_reg <= `OTFS_RST_POLARITY;
         sel4_reg <= `OTFS_RST_TERM_FUNC;
         rsel_reg <= `OTFS_RST_RELAY_FUNC;
      end else if (wr_ok) begin
         if (i_paddr == `OTFS_ADDR_FAULT_MODE) mode_reg <= i_pwdata[1:0];
         if (i_paddr == `OTFS_ADDR_POLARITY) pol_reg <= i_pwdata[5:0];
         if (i_paddr == 8'h10) sel4_reg <= i_pwdata[5:0];
         if (i_paddr == `OTFS_ADDR_RELAY_FUNC) rsel_reg <= i_pwdata[5:0];
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);
   property p_oc_low; o_terminal_out == 5'h00; endproperty
   a_oc_low: assert property (p_oc_low) else $error("terminal driven high");
   property p_ready; i_psel && !i_penable |=> o_pready ##1 !o_pready; endproperty
   a_ready: assert property (p_ready) else $error("ready not a single cycle after setup");
   property p_refuse; i_psel && !i_penable && i_paddr > 8'h20 |=> o_pslverr && o_prdata == 32'h0; endproperty
   a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
   property p_fault3; mode_reg == `OTFS_FAULT_3BIT |=> o_terminal_oe_n[2:0] == $past(code3); endproperty
   a_fault3: assert property (p_fault3) else $error("3-bit code wrong");
   property p_fault4; mode_reg == `OTFS_FAULT_4BIT |=> o_terminal_oe_n[3:0] == $past(code4); endproperty
   a_fault4: assert property (p_fault4) else $error("4-bit code wrong");
   // Sampled reset keeps the release edge, still a reset edge for the design, out of the antecedent
   property p_run4; i_rstn && sel4_reg == `OTFS_CODE_RUN |=> o_terminal_oe_n[4] == $past(run_oe_n); endproperty
   a_run4: assert property (p_run4) else $error("running not routed");
   property p_relay; i_rstn && rsel_reg == `OTFS_CODE_FAULT |=> o_relay_coil == $past(relay_on); endproperty
   a_relay: assert property (p_relay) else $error("relay level wrong");
   property p_undef4; sel4_reg > 6'h38 |=> o_terminal_oe_n[4] == !$past(pol_reg[4]); endproperty
   a_undef4: assert property (p_undef4) else $error("undefined code not idle");
   c_mode4: cover property (mode_reg == `OTFS_FAULT_4BIT);
   c_refused: cover property (o_pslverr);
   c_undef: cover property (sel4_reg > 6'h38 && o_relay_coil);
endmodule
`default_nettype wire

// ### otfs_load.sv
// Pull-up loads on the open-collector terminals
`timescale 1ns/1ps
`default_nettype none
module otfs_load (
   input wire logic [4:0] i_oe_n,
   input wire logic [4:0] i_out,
   output logic [4:0] o_pin
);
   // A released terminal floats up to the load supply
   assign o_pin = i_oe_n | i_out;
endmodule
`default_nettype wire

// ### tb_otfs_core.sv
// Self-checking bench for the output terminal select block
`timescale 1ns/1ps
`default_nettype none
`include "otfs_defs.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
   $display("Error at %0t: got %h exp %h", $time, a, e); end end
module tb_otfs_core;
   logic i_core_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0;
   logic [56:0] st = 57'h0;
   logic [3:0] fbits = 4'h0;
   wire [31:0] o_prdata;
   wire o_pready, o_pslverr, o_relay_coil;
   wire [4:0] o_terminal_out, o_terminal_oe_n, pins;
   logic [31:0] rdata;
   logic rerr;
   int n_errors = 0;
   int checked = 0;
   always #2.5 i_core_clk = ~i_core_clk;
   otfs_core u_otfs_core (
      .i_core_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
      .i_running(st[0]), .i_constant_speed_reached(st[1]), .i_set_freq_overreached(st[2]),
      .i_overload_notice_first(st[3]), .i_pid_deviation_flag(st[4]), .i_fault_flag(st[5]),
      .i_set_freq_reached(st[6]), .i_over_torque(st[7]), .i_momentary_power_loss(st[8]), .i_supply_low_flag(st[9]),
      .i_torque_limited(st[10]), .i_run_time_exceeded(st[11]), .i_power_on_time_exceeded(st[12]),
      .i_thermal_protect_alarm(st[13]), .i_brake_release(st[19]), .i_brake_error(st[20]),
      .i_zero_hertz_detect(st[21]), .i_speed_deviation_max(st[22]), .i_position_done(st[23]),
      .i_set_freq_overreached_second(st[24]), .i_set_freq_reached_second(st[25]),
      .i_overload_notice_second(st[26]), .i_voltage_input_disconnect(st[27]), .i_current_input_disconnect(st[28]),
      .i_second_voltage_input_disconnect(st[29]), .i_pid_feedback_compare(st[31]),
      .i_comm_line_disconnect(st[32]), .i_logic_result(st[38:33]), .i_capacitor_life_warning(st[39]),
      .i_fan_speed_drop(st[40]), .i_start_contact_flag(st[41]), .i_heatsink_overheat_warning(st[42]),
      .i_low_current_flag(st[43]), .i_sequence_output(st[49:44]), .i_drive_ready(st[50]),
      .i_forward_rotation(st[51]), .i_reverse_rotation(st[52]), .i_major_failure(st[53]),
      .i_window_compare(st[56:54]), .i_fault_code_bits(fbits), .i_terminal_pin(pins), .o_terminal_out,
      .o_terminal_oe_n, .o_relay_coil);
   otfs_load u_otfs_load (.i_oe_n(o_terminal_oe_n), .i_out(o_terminal_out), .o_pin(pins));
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge i_core_clk);
   endtask
   // Ready is sampled at the edge, before that edge's updates land
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_core_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 16);
      rdata = o_prdata;
      rerr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (n >= 16) begin
         $display("Error at %0t: no ready from slave", $time);
         n_errors++;
         stop_test();
      end
   endtask
   function automatic logic dfn(input int c);
      return c < 57 && !(c inside {[14:18], 30});
   endfunction
   initial begin
      cyc(4);
      i_rstn <= 1'b1;
      apb(1'b0, `OTFS_ADDR_RELAY_FUNC, 32'h0); `CHK(rdata, 32'h5)
      apb(1'b0, `OTFS_ADDR_POLARITY, 32'h0); `CHK(rdata, 32'h20)
      apb(1'b0, `OTFS_ADDR_FAULT_MODE, 32'h0); `CHK(rdata, 32'h0)
      `CHK(o_relay_coil, 1'b1)
      $display("Reset test done");
      for (int c = 0; c < 64; c++) begin
         apb(1'b1, 8'h10, 32'(c));
         // Every other source high: only the selected one may reach the pin
         st <= ~(57'h1 << c);
         cyc(2);
         `CHK(o_terminal_oe_n[4], 1'b1)
         `CHK(o_terminal_oe_n[3:0], c != 0 ? 4'h0 : 4'hf)
         // Undefined codes see every source high and must stay off
         st <= dfn(c) ? 57'h1 << c : ~57'h0;
         cyc(2);
         `CHK(o_terminal_oe_n[4], !dfn(c))
         `CHK(o_terminal_oe_n[3:0], (c == 0 || !dfn(c)) ? 4'h0 : 4'hf)
      end
      $display("Selection test done");
      apb(1'b1, `OTFS_ADDR_POLARITY, 32'h3f);
      st <= 57'h0;
      cyc(2);
      `CHK({o_relay_coil, o_terminal_oe_n}, 6'h20)
      apb(1'b1, `OTFS_ADDR_POLARITY, 32'h0);
      cyc(2);
      `CHK({o_relay_coil, o_terminal_oe_n}, 6'h1f)
      $display("Polarity test done");
      st <= 57'h1;
      fbits <= 4'h6;
      for (int m = 1; m < 4; m++) begin
         apb(1'b1, `OTFS_ADDR_FAULT_MODE, 32'(m));
         cyc(2);
         `CHK(o_terminal_oe_n, m == 1 ? 5'h11 : m == 2 ? 5'h19 : 5'h10)
      end
      $display("Fault code test done");
      apb(1'b0, 8'h24, 32'h0); `CHK({rerr, rdata}, {1'b1, 32'h0})
      apb(1'b1, `OTFS_ADDR_STATUS, 32'hffff_ffff); `CHK(rerr, 1'b1)
      cyc(4);
      apb(1'b0, `OTFS_ADDR_STATUS, 32'h0); `CHK(rdata, 32'h100f)
      apb(1'b0, 8'h10, 32'h0); `CHK(rdata, 32'h3f)
      apb(1'b0, 8'h19, 32'h0); `CHK({rerr, rdata}, {1'b1, 32'h0})
      $display("Bus test done");
      stop_test();
   end
endmodule
bind otfs_core otfs_chk u_otfs_chk (.i_core_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
   .o_prdata, .o_pready, .o_pslverr, .i_running, .i_fault_flag, .i_fault_code_bits, .o_terminal_out,
   .o_terminal_oe_n, .o_relay_coil);
`default_nettype wire
